// File: include/dpi_pkg.sv
package dpi_pkg;
  localparam int BANKS      = 4;
  localparam int BA_W       = 2;
  localparam int ADDR_W     = 14;
  localparam int AP_BIT     = 10;
  localparam int DQ_W       = 16;
  localparam int BYTE_W     = 8;
  localparam int LANES      = 2;
  localparam int BURST      = 4;
  localparam int BEATS_W    = 3;
  localparam int CNT_W      = 4;
  localparam int MEM_AW     = 8;
  localparam int RD_LAT     = 3;
  localparam int WR_LAT     = 2;
  localparam int EMR_STRB_SE  = 10;
  localparam int EMR_AUX_STRB_EN = 11;
  localparam logic [BA_W-1:0] BA_BASE_MODE = 2'h0;
  localparam logic [BA_W-1:0] BA_EXT_MODE  = 2'h1;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   memory_slice_sel;
    logic [ADDR_W-1:0] addr_lines;
  } dpi_cmd_t;

  typedef struct packed {
    logic [DQ_W-1:0]  dq;
    logic [LANES-1:0] strobe;
    logic [LANES-1:0] strobe_n;
  } dpi_rd_t;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MODE_LOAD, CMD_DESEL
  } dpi_op_t;
endpackage

// File: design/dpi_ddr2_pins.sv
// Behaviour
// - address and control sampled on rising crossing of the differential clock
// - read data timed to both crossings of the differential clock
// - clock gate high runs clocks, buffers, drivers; low stops them
// - gate low with banks idle: precharge power-down or self refresh; else active
// - gate sampled on clock edges for power-down entry, exit, self-refresh entry
// - self-refresh exit and output disable follow the gate without the clock
// - in power-down and self refresh only clock and gate inputs stay enabled
// - select high masks commands; strobes, mask, clocks, gate bypass it
// - select with row, column, write strobes decodes the command
// - activate, read, write, single precharge go to the selected bank
// - activate takes row; read and write take column and auto-precharge bit
// - precharge scope bit low closes selected bank, high closes all
// - mode load takes op code; bank select picks base or extended register
// - termination applies only to data, strobes, aux strobe and mask
// - beats with mask sampled high are not stored
// - mask sampled on both strobe edges
// - lower mask qualifies bits 0-7, upper mask bits 8-15
// - lower strobe times bits 0-7, upper strobe bits 8-15
// - eight-bit organisation: shared mask pin becomes aux read strobe if enabled
// - strobe edge-aligned on reads, centred in writes, captures write data
// - strobe differential or single-ended per extended mode register
`timescale 1ns/10ps
module dpi_ddr2_pins #(
  parameter int X8_ORG = 0
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       nrst_i,
  input  wire logic                       ce_i,
  input  wire logic                       diff_clk_pair_i,
  input  wire logic                       clk_gate_i,
  input  wire dpi_pkg::dpi_cmd_t          cmd_i,
  input  wire logic                       termination_ctl_i,
  input  wire logic [dpi_pkg::DQ_W-1:0]   dq_i,
  input  wire logic [dpi_pkg::LANES-1:0]  data_strobe_i,
  input  wire logic [dpi_pkg::LANES-1:0]  write_mask_i,
  output dpi_pkg::dpi_rd_t                rd_o,
  output logic                            dq_oe_o,
  output logic                            read_strobe_aux_o,
  output logic                            read_strobe_aux_oe_o,
  output logic                            term_on_o,
  output logic [dpi_pkg::BANKS-1:0]       bank_open_o,
  output logic                            pwr_down_o,
  output logic                            self_ref_o,
  output logic [dpi_pkg::ADDR_W-1:0]      mode_base_o,
  output logic [dpi_pkg::ADDR_W-1:0]      mode_ext_o
);
  typedef enum { ST_RUN, ST_PD, ST_SR } dpi_pwr_t;

  // three-stage samplers for all pins from the link side
  localparam int SW = 4 + dpi_pkg::LANES * 2 + dpi_pkg::DQ_W + $bits(dpi_pkg::dpi_cmd_t);
  logic [SW-1:0] s1_q, s2_q, s3_q, pins;
  assign pins = {diff_clk_pair_i, clk_gate_i, termination_ctl_i, 1'b0,
                 data_strobe_i, write_mask_i, dq_i, cmd_i};
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce_i) begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit counts only once the second and third stage agree
  logic [SW-1:0] f_q;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      f_q <= '0;
    end else if (ce_i) begin
      f_q <= (s2_q & s3_q) | (f_q & (s2_q | s3_q));
    end
  end

  localparam int CW = $bits(dpi_pkg::dpi_cmd_t);
  localparam int P_LCLK = SW - 1;
  localparam int P_GATE = SW - 2;
  localparam int P_TERM = SW - 3;
  localparam int P_DQS = CW + dpi_pkg::DQ_W + dpi_pkg::LANES;
  localparam int P_MASK = CW + dpi_pkg::DQ_W;

  dpi_pkg::dpi_cmd_t          cmd;
  logic [dpi_pkg::DQ_W-1:0]   dq_f;
  logic [dpi_pkg::LANES-1:0]  dqs_f, mask_f;
  logic                       lclk_f, gate_f, term_f;
  assign cmd    = dpi_pkg::dpi_cmd_t'(f_q[CW-1:0]);
  assign dq_f   = f_q[P_MASK-1:CW];
  assign mask_f = f_q[P_DQS-1:P_MASK];
  assign dqs_f  = f_q[P_TERM-1-1:P_DQS];
  assign lclk_f = f_q[P_LCLK];
  assign gate_f = f_q[P_GATE];
  assign term_f = f_q[P_TERM];

  // clock edge detection
  logic lclk_d_q;
  logic [dpi_pkg::LANES-1:0] dqs_d_q;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lclk_d_q <= 1'b0;
      dqs_d_q  <= '0;
    end else if (ce_i) begin
      lclk_d_q <= lclk_f;
      dqs_d_q  <= dqs_f;
    end
  end
  logic lclk_rise, lclk_fall;
  assign lclk_rise = lclk_f & ~lclk_d_q;
  assign lclk_fall = ~lclk_f & lclk_d_q;

  // power state
  dpi_pwr_t pwr_q;
  logic     gate_prev_q;
  logic     any_open;
  logic     running;
  assign any_open = |bank_open_o;
  assign running  = (pwr_q == ST_RUN) && gate_prev_q && gate_f;

  // command decode, masked by select and by low-power state
  dpi_pkg::dpi_op_t op;
  always_comb begin
    op = dpi_pkg::CMD_NOP;
    if (cmd.cs_n) begin
      op = dpi_pkg::CMD_DESEL;
    end else begin
      case ({cmd.ras_n, cmd.cas_n, cmd.we_n})
        3'h3:    op = dpi_pkg::CMD_ACT;
        3'h5:    op = dpi_pkg::CMD_RD;
        3'h4:    op = dpi_pkg::CMD_WR;
        3'h2:    op = dpi_pkg::CMD_PRE;
        3'h1:    op = dpi_pkg::CMD_REF;
        3'h0:    op = dpi_pkg::CMD_MODE_LOAD;
        default: op = dpi_pkg::CMD_NOP;
      endcase
    end
  end

  // inputs other than clock, gate and the refresh that enters self refresh are ignored unless running
  logic cmd_take;
  assign cmd_take = lclk_rise && running;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwr_q       <= ST_RUN;
      gate_prev_q <= 1'b0;
    end else if (ce_i) begin
      if (pwr_q == ST_SR && gate_f) begin
        pwr_q <= ST_RUN;
      end
      if (lclk_rise) begin
        gate_prev_q <= gate_f;
        case (pwr_q)
          ST_RUN: begin
            if (gate_prev_q && !gate_f) begin
              if (!cmd.cs_n && op == dpi_pkg::CMD_REF && !any_open) begin
                pwr_q <= ST_SR;
              end else begin
                pwr_q <= ST_PD;
              end
            end
          end
          ST_PD: if (gate_f) pwr_q <= ST_RUN;
          ST_SR: pwr_q <= ST_SR;
          default: pwr_q <= ST_RUN;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwr_down_o <= 1'b0;
      self_ref_o <= 1'b0;
    end else if (ce_i) begin
      pwr_down_o <= (pwr_q == ST_PD);
      self_ref_o <= (pwr_q == ST_SR);
    end
  end

  // bank state and mode registers
  logic [dpi_pkg::BA_W-1:0] ba;
  assign ba = cmd.memory_slice_sel;
  logic ap;
  assign ap = cmd.addr_lines[dpi_pkg::AP_BIT];
  logic [dpi_pkg::ADDR_W-1:0] row_q [dpi_pkg::BANKS];
  logic [dpi_pkg::BANKS-1:0]  ap_pend_q;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bank_open_o <= '0;
      ap_pend_q   <= '0;
      for (int i = 0; i < dpi_pkg::BANKS; i++) row_q[i] <= '0;
    end else if (ce_i && cmd_take) begin
      case (op)
        dpi_pkg::CMD_ACT: begin
          bank_open_o[ba] <= 1'b1;
          row_q[ba]       <= cmd.addr_lines;
        end
        dpi_pkg::CMD_RD, dpi_pkg::CMD_WR: begin
          ap_pend_q[ba] <= ap;
        end
        dpi_pkg::CMD_PRE: begin
          if (ap) begin
            bank_open_o <= '0;
          end else begin
            bank_open_o[ba] <= 1'b0;
          end
        end
        default: begin
          bank_open_o <= bank_open_o & ~(ap_pend_q & ~'0);
          ap_pend_q   <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_base_o <= '0;
      mode_ext_o  <= '0;
    end else if (ce_i && cmd_take && op == dpi_pkg::CMD_MODE_LOAD) begin
      if (ba == dpi_pkg::BA_BASE_MODE) mode_base_o <= cmd.addr_lines;
      if (ba == dpi_pkg::BA_EXT_MODE)  mode_ext_o  <= cmd.addr_lines;
    end
  end

  // column address of the burst
  logic [dpi_pkg::MEM_AW-1:0] col_q;
  logic [dpi_pkg::BA_W-1:0]   bank_q;
  logic [dpi_pkg::BEATS_W-1:0] wr_beats_q, rd_beats_q;
  logic [dpi_pkg::CNT_W-1:0]  rd_wait_q;

  // storage, one array per byte lane
  logic [dpi_pkg::BYTE_W-1:0] mem_q [dpi_pkg::LANES][2**dpi_pkg::MEM_AW];
  logic [dpi_pkg::MEM_AW-1:0] wptr, rptr;
  assign wptr = col_q + dpi_pkg::MEM_AW'(dpi_pkg::BURST - wr_beats_q);
  assign rptr = col_q + dpi_pkg::MEM_AW'(dpi_pkg::BURST - rd_beats_q);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      col_q      <= '0;
      bank_q     <= '0;
      wr_beats_q <= '0;
      rd_beats_q <= '0;
      rd_wait_q  <= '0;
    end else if (ce_i) begin
      if (cmd_take && op == dpi_pkg::CMD_WR) begin
        col_q      <= cmd.addr_lines[dpi_pkg::MEM_AW-1:0];
        bank_q     <= ba;
        wr_beats_q <= dpi_pkg::BEATS_W'(dpi_pkg::BURST);
      end else if (cmd_take && op == dpi_pkg::CMD_RD) begin
        col_q      <= cmd.addr_lines[dpi_pkg::MEM_AW-1:0];
        bank_q     <= ba;
        rd_wait_q  <= dpi_pkg::CNT_W'(dpi_pkg::RD_LAT);
      end else begin
        if (rd_wait_q != '0 && lclk_rise) begin
          rd_wait_q <= rd_wait_q - 1'b1;
          if (rd_wait_q == 1) rd_beats_q <= dpi_pkg::BEATS_W'(dpi_pkg::BURST);
        end
        if (rd_beats_q != '0 && (lclk_rise || lclk_fall)) rd_beats_q <= rd_beats_q - 1'b1;
        if (wr_beats_q != '0 && (dqs_f != dqs_d_q)) wr_beats_q <= wr_beats_q - 1'b1;
      end
    end
  end

  // write capture on both strobe edges, per lane
  for (genvar l = 0; l < dpi_pkg::LANES; l++) begin : g_lane
    always_ff @(posedge clk_sys_i) begin
      if (ce_i && wr_beats_q != '0 && gate_f) begin
        if (dqs_f[l] != dqs_d_q[l] && !mask_f[l]) begin
          mem_q[l][wptr] <= dq_f[l*dpi_pkg::BYTE_W +: dpi_pkg::BYTE_W];
        end
      end
    end
  end

  // read drive: data and strobe change on both clock crossings
  logic ext_se, ext_aux;
  assign ext_se  = mode_ext_o[dpi_pkg::EMR_STRB_SE];
  assign ext_aux = mode_ext_o[dpi_pkg::EMR_AUX_STRB_EN] && (X8_ORG != 0);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_o                 <= '0;
      dq_oe_o              <= 1'b0;
      read_strobe_aux_o    <= 1'b0;
      read_strobe_aux_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (!gate_f) begin
        rd_o                 <= '0;
        dq_oe_o              <= 1'b0;
        read_strobe_aux_oe_o <= 1'b0;
      end else if (rd_beats_q != '0 && (lclk_rise || lclk_fall)) begin
        rd_o.dq       <= {mem_q[1][rptr], mem_q[0][rptr]};
        // toggle per beat so the first beat also carries a strobe edge
        rd_o.strobe   <= ~rd_o.strobe;
        rd_o.strobe_n <= ext_se ? '0 : rd_o.strobe;
        dq_oe_o       <= 1'b1;
        read_strobe_aux_o    <= ~rd_o.strobe[0];
        read_strobe_aux_oe_o <= ext_aux;
      end else if (rd_beats_q == '0) begin
        dq_oe_o              <= 1'b0;
        rd_o.strobe          <= '0;
        read_strobe_aux_oe_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      term_on_o <= 1'b0;
    end else if (ce_i) begin
      // termination off from the cycle after this end starts driving the data pins
      term_on_o <= term_f && running && !dq_oe_o;
    end
  end
endmodule

// File: testbench/dpi_ddr2_pins_monitor.sv
`timescale 1ns/10ps
module dpi_ddr2_pins_monitor #(
  parameter int X8_ORG = 0
) (
  input wire logic                       clk_sys_i,
  input wire logic                       nrst_i,
  input wire logic                       clk_gate_i,
  input wire logic                       termination_ctl_i,
  input wire dpi_pkg::dpi_rd_t           rd_o,
  input wire logic                       dq_oe_o,
  input wire logic                       read_strobe_aux_oe_o,
  input wire logic                       term_on_o,
  input wire logic [dpi_pkg::BANKS-1:0]  bank_open_o,
  input wire logic                       pwr_down_o,
  input wire logic                       self_ref_o,
  input wire logic [dpi_pkg::ADDR_W-1:0] mode_base_o,
  input wire logic [dpi_pkg::ADDR_W-1:0] mode_ext_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence s_term_off; !termination_ctl_i [*8]; endsequence
  sequence s_gate_off; !clk_gate_i [*6]; endsequence
  sequence s_sr_wake; self_ref_o ##1 $rose(clk_gate_i); endsequence
  AST_PD_XOR: assert property (!(pwr_down_o && self_ref_o))
    else $error("power-down and self refresh both set");
  AST_SR_IDLE: assert property ($rose(self_ref_o) |-> bank_open_o == 4'h0)
    else $error("self refresh with a row open");
  AST_PD_HOLD: assert property (pwr_down_o && $past(pwr_down_o) |-> $stable(bank_open_o))
    else $error("bank state moved in power-down");
  AST_SR_HOLD: assert property (self_ref_o |=> $stable(mode_base_o) && $stable(mode_ext_o))
    else $error("mode loaded in self refresh");
  AST_OE_GATE: assert property (s_gate_off |-> !dq_oe_o)
    else $error("drivers on with gate low");
  AST_DIFF: assert property (dq_oe_o && !mode_ext_o[10] |-> rd_o.strobe_n == ~rd_o.strobe)
    else $error("strobe pair not complementary");
  AST_AUX: assert property (read_strobe_aux_oe_o |-> X8_ORG != 0 && mode_ext_o[11])
    else $error("aux strobe driven without option");
  AST_TERM: assert property (s_term_off |-> !term_on_o)
    else $error("termination on while control low");
  AST_SR_EXIT: assert property (s_sr_wake |-> ##[0:8] !self_ref_o)
    else $error("self refresh exit too slow");
  AST_RD_BEAT: assert property ($rose(dq_oe_o) |-> ##[0:40] $changed(rd_o.strobe))
    else $error("read strobe never toggled");
endmodule

// File: testbench/dpi_ctl_model.sv
`timescale 1ns/10ps
module dpi_ctl_model (
  input  wire logic         clk_sys_i,
  output logic              lclk_o,
  output logic              gate_o,
  output dpi_pkg::dpi_cmd_t cmd_o,
  output logic [15:0]       dq_o,
  output logic [1:0]        dqs_o,
  output logic [1:0]        mask_o
);
  logic [2:0]  ph_q = 3'h0;
  logic [5:0]  wt_q = 6'h00;
  logic [19:0] pend_q;
  logic        pv_q = 1'b0;
  logic        g_q = 1'b1;
  logic [63:0] wd_q;
  logic [7:0]  wm_q;
  initial begin
    lclk_o = 1'b0;
    gate_o = 1'b1;
    cmd_o = 20'h70000;
    dq_o = 16'h0000;
    dqs_o = 2'h0;
    mask_o = 2'h0;
  end
  always @(posedge clk_sys_i) begin
    ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
    if (ph_q == 3'h5) lclk_o <= ~lclk_o;
    // change on the fall so inputs are settled at the rise
    if (ph_q == 3'h5 && lclk_o) begin
      cmd_o <= pv_q ? pend_q : 20'h70000;
      gate_o <= g_q;
      pv_q <= 1'b0;
      if (pv_q && pend_q[19:16] == 4'h4) wt_q <= 6'h01;
    end
    if (wt_q != 6'h00) wt_q <= (wt_q == 6'h32) ? 6'h00 : wt_q + 6'h01;
    if (wt_q % 6 == 3 && wt_q >= 27 && wt_q <= 45) begin
      dq_o <= wd_q[16*((wt_q-27)/6) +: 16];
      mask_o <= wm_q[2*((wt_q-27)/6) +: 2];
    end
    if (wt_q % 6 == 0 && wt_q >= 30 && wt_q <= 48) dqs_o <= ~dqs_o;
    // released bus must not keep the last beat
    if (wt_q == 6'h32) dq_o <= ~dq_o;
  end
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a,
                       input logic g);
    @(posedge clk_sys_i);
    for (int i = 0; i < 6 && ph_q != 3'h2; i++) @(posedge clk_sys_i);
    pend_q <= {c, b, a};
    g_q <= g;
    pv_q <= 1'b1;
    repeat (32) @(posedge clk_sys_i);
  endtask
  task automatic load(input logic [63:0] d, input logic [7:0] m);
    wd_q = d;
    wm_q = m;
  endtask
endmodule

// File: testbench/ddr2_sdram_pin_interface_test.sv
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module ddr2_sdram_pin_interface_test;
  logic              clk_sys_i = 1'b0;
  logic              nrst_i;
  logic              term_q;
  logic              lclk, gate, ps, oe, aux, aux_oe, term_on, pd, sr;
  dpi_pkg::dpi_cmd_t cmd;
  dpi_pkg::dpi_rd_t  rd;
  logic [15:0]       dq, beat [4];
  logic [1:0]        dqs, wmask;
  logic [3:0]        bank;
  logic [13:0]       mb, me;
  logic [23:0]       rows [8] = '{24'h001230, 24'h040080, 24'h300551, 24'h380005,
                                  24'h200004, 24'h3C000C, 24'h204000, 24'hB40000};
  logic [63:0]       exp_rd = 64'h4444_CCCC_22BB_AA11;
  int                n_fail = 0, num_checks = 0, nb;
  always #2 clk_sys_i = ~clk_sys_i;
  dpi_ctl_model i_ctl (.clk_sys_i(clk_sys_i), .lclk_o(lclk), .gate_o(gate), .cmd_o(cmd),
    .dq_o(dq), .dqs_o(dqs), .mask_o(wmask));
  dpi_ddr2_pins i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .diff_clk_pair_i(lclk), .clk_gate_i(gate), .cmd_i(cmd), .termination_ctl_i(term_q),
    .dq_i(dq), .data_strobe_i(dqs), .write_mask_i(wmask), .rd_o(rd), .dq_oe_o(oe),
    .read_strobe_aux_o(aux), .read_strobe_aux_oe_o(aux_oe), .term_on_o(term_on),
    .bank_open_o(bank), .pwr_down_o(pd), .self_ref_o(sr), .mode_base_o(mb),
    .mode_ext_o(me));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    nrst_i = 1'b0;
    term_q = 1'b0;
    repeat (16) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    `CHK(bank, 4'h0)
    $display("reset test done");
    foreach (rows[i]) begin
      i_ctl.issue(rows[i][23:20], rows[i][19:18], rows[i][17:4], 1'b1);
      `CHK(bank, rows[i][3:0])
    end
    `CHK(mb, 14'h0123)
    `CHK(me, 14'h0008)
    $display("command table done");
    i_ctl.issue(4'h3, 2'h1, 14'h0005, 1'b1);
    i_ctl.load(64'h4444_3333_2222_1111, 8'h00);
    i_ctl.issue(4'h4, 2'h1, 14'h0010, 1'b1);
    repeat (40) @(posedge clk_sys_i);
    // lane masks per beat: low, high, none, both
    i_ctl.load(64'hDDDD_CCCC_BBBB_AAAA, 8'hC9);
    i_ctl.issue(4'h4, 2'h1, 14'h0010, 1'b1);
    repeat (40) @(posedge clk_sys_i);
    ps = rd.strobe[0];
    i_ctl.issue(4'h5, 2'h1, 14'h0010, 1'b1);
    nb = 0;
    for (int k = 0; k < 150 && nb < 4; k++) begin
      @(posedge clk_sys_i);
      #1;
      if (oe === 1'b1 && rd.strobe[0] !== ps) begin
        beat[nb] = rd.dq;
        nb++;
      end
      ps = rd.strobe[0];
    end
    `CHK(nb, 4)
    for (int k = 0; k < 4; k++) `CHK(beat[k], exp_rd[16*k +: 16])
    $display("masked write test done");
    repeat (40) @(posedge clk_sys_i);
    i_ctl.issue(4'h7, 2'h0, 14'h0000, 1'b0);
    `CHK({pd, sr, oe}, 3'b100)
    i_ctl.issue(4'h3, 2'h2, 14'h0000, 1'b0);
    `CHK(bank, 4'h2)
    i_ctl.issue(4'h7, 2'h0, 14'h0000, 1'b1);
    `CHK(pd, 1'b0)
    i_ctl.issue(4'h2, 2'h0, 14'h0400, 1'b1);
    i_ctl.issue(4'h1, 2'h0, 14'h0000, 1'b0);
    `CHK({pd, sr}, 2'b01)
    i_ctl.issue(4'h0, 2'h0, 14'h0777, 1'b0);
    `CHK(mb, 14'h0123)
    i_ctl.issue(4'h7, 2'h0, 14'h0000, 1'b1);
    `CHK(sr, 1'b0)
    $display("power test done");
    term_q <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    `CHK(term_on, 1'b1)
    term_q <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
    `CHK(term_on, 1'b0)
    $display("termination test done");
    tally_and_finish();
  end
endmodule
bind dpi_ddr2_pins dpi_ddr2_pins_monitor #(.X8_ORG(X8_ORG)) u_mon (.clk_sys_i(clk_sys_i),
  .nrst_i(nrst_i), .clk_gate_i(clk_gate_i), .termination_ctl_i(termination_ctl_i),
  .rd_o(rd_o), .dq_oe_o(dq_oe_o), .read_strobe_aux_oe_o(read_strobe_aux_oe_o),
  .term_on_o(term_on_o), .bank_open_o(bank_open_o), .pwr_down_o(pwr_down_o),
  .self_ref_o(self_ref_o), .mode_base_o(mode_base_o), .mode_ext_o(mode_ext_o));
